// >>> hw/ecu_top.sv
/*
 Energy detection scan and clear channel assessment unit with an
 Avalon-MM register slave. Assumes radio status inputs are synchronous.
*/
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module ecu_top #(
   parameter int unsigned P_SYMBOL_CYCLES = ecu_pkg::SYMBOL_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // avalon-mm slave
   input wire logic [4:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // receiver status
   input wire logic [7:0] i_rssi,
   input wire logic i_sfd_detect,
   input wire logic i_frame_rx_active,
   input wire logic i_corr_peak,
   input wire logic [7:0] i_corr_value,
   input wire logic i_receive_rampup_done_event,
   // events
   output logic o_energy_scan_done_event,
   output logic o_energy_scan_aborted_event,
   output logic o_medium_free_event,
   output logic o_medium_occupied_event,
   output logic o_assessment_aborted_event,
   // tasks to the radio
   output logic o_transmit_rampup_task,
   output logic o_receive_stop_task,
   output logic o_radio_disable_task
);
   import ecu_pkg::*;
   localparam logic [15:0] WIN_CYC = 16'(WINDOW_SYMBOLS * P_SYMBOL_CYCLES);

   ecu_ed_st_t ed_st_r;
   ecu_cca_st_t cca_st_r;
   logic [3:0] shorts_r;
   logic [7:0] iter_r;
   logic [31:0] ctrl_r;
   logic [7:0] result_r;
   logic [EVT_N-1:0] evt_r;
   logic [7:0] iter_left_r;
   logic [7:0] max_r;
   logic carrier_r;
   logic [15:0] cca_age_r;
   logic avg_done;
   logic [7:0] avg_val;
   logic [7:0] avg_first;
   logic peak_hit;

   // bus decode
   wire wr_go = i_write && !o_waitrequest;
   wire [31:0] bmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                        {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
   wire [31:0] wmerge_ctrl = (ctrl_r & ~bmask) | (i_writedata & bmask);
   wire sel_tasks = wr_go && (i_address == OFS_TASKS);
   wire sel_events = wr_go && (i_address == OFS_EVENTS);
   wire sel_shorts = wr_go && (i_address == OFS_SHORTS);
   wire sel_iter = wr_go && (i_address == OFS_ITER) && i_byteenable[0];
   wire sel_ctrl = wr_go && (i_address == OFS_CTRL);
   wire [3:0] tsk = sel_tasks ? (i_writedata[3:0] & bmask[3:0]) : 4'h0;
   wire [EVT_N-1:0] evt_clr = sel_events ? (i_writedata[EVT_N-1:0] & bmask[EVT_N-1:0]) : '0;
   wire [31:0] rd_mux =
      (i_address == OFS_EVENTS) ? {27'h0, evt_r} :
      (i_address == OFS_SHORTS) ? {28'h0, shorts_r} :
      (i_address == OFS_ITER) ? {24'h0, iter_r} :
      (i_address == OFS_RESULT) ? {24'h0, result_r} :
      (i_address == OFS_CTRL) ? ctrl_r : 32'h00000000;

   // control fields
   wire [2:0] mode = ctrl_r[MODE_LSB +: 3];
   // energy threshold compared against the averaged strength; cthr against correlator peak values
   wire [7:0] thr = ctrl_r[THR_LSB +: 8];
   wire [7:0] cthr = ctrl_r[CTHR_LSB +: 8];
   wire [7:0] lim = ctrl_r[LIM_LSB +: 8];
   wire corr_on = (lim != 8'h00);

   // energy scan control
   wire ed_run = (ed_st_r == ED_RUN);
   wire cca_run = (cca_st_r == CCA_RUN);
   wire both_idle = !ed_run && !cca_run;
   wire ed_go = tsk[TSK_ED_BEGIN] && both_idle;
   wire ed_abort = ed_run && tsk[TSK_ED_ABORT];
   wire ed_iter_end = ed_run && avg_done && !ed_abort;
   wire ed_last = ed_iter_end && (iter_left_r <= 8'h01);
   wire [7:0] ed_max_nxt = (avg_val > max_r) ? avg_val : max_r;

   // assessment control
   // ramp-up done shortcut
   wire cca_begin = tsk[TSK_CCA_BEGIN] || (i_receive_rampup_done_event && shorts_r[SC_RDY_CCA]);
   wire cca_go = cca_begin && both_idle && !tsk[TSK_ED_BEGIN];
   wire cca_abort = cca_run && tsk[TSK_CCA_ABORT];
   wire carrier_seen = carrier_r || i_sfd_detect || i_frame_rx_active || peak_hit;
   wire cca_early = cca_run && !cca_abort && (mode == MODE_CARRIER) && corr_on && (i_sfd_detect || peak_hit);
   wire cca_end = cca_run && avg_done && !cca_abort && !cca_early;
   wire energy_busy = (avg_val >= thr);
   wire busy_dec = (mode == MODE_CARRIER) ? carrier_seen :
                   (mode == MODE_AND) ? (energy_busy && carrier_seen) :
                   (mode == MODE_OR) ? (energy_busy || carrier_seen) : energy_busy;
   wire free_ev = cca_end && !busy_dec;
   wire occ_ev = cca_early || (cca_end && busy_dec);

   // shared averager; a restart between iterations leaves one idle cycle between windows
   wire avg_start = ed_go || cca_go || (ed_iter_end && !ed_last);
   wire avg_stop = ed_abort || cca_abort || cca_early;
   wire [EVT_N-1:0] evt_set = {cca_abort, occ_ev, free_ev, ed_abort, ed_last};

   ecu_sym_avg #(
      .P_SYMBOL_CYCLES(P_SYMBOL_CYCLES)
   ) u_avg (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_start(avg_start),
      .i_stop(avg_stop),
      .i_rssi(i_rssi),
      .o_done(avg_done),
      .o_avg(avg_val),
      .o_first(avg_first)
   );

   ecu_peak_cnt u_peak (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_clear(cca_go),
      .i_enable(cca_run),
      .i_peak(i_corr_peak),
      .i_value(i_corr_value),
      .i_threshold(cthr),
      .i_limit(lim),
      .o_hit(peak_hit)
   );

   // bus slave: one wait cycle per access
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_waitrequest <= 1'b1;
         o_readdata <= 32'h00000000;
      end else begin
         o_waitrequest <= !((i_read || i_write) && o_waitrequest);
         if (i_read && o_waitrequest) begin
            o_readdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         shorts_r <= SHORTS_RST;
         iter_r <= ITER_RST;
         ctrl_r <= CTRL_RST;
      end else begin
         if (sel_shorts) begin
            shorts_r <= (shorts_r & ~bmask[3:0]) | (i_writedata[3:0] & bmask[3:0]);
         end
         if (sel_iter) begin
            iter_r <= i_writedata[7:0];
         end
         if (sel_ctrl) begin
            ctrl_r <= wmerge_ctrl & CTRL_MASK;
         end
      end
   end

   // sticky events; a set in the clearing cycle wins
   genvar g;
   for (g = 0; g < EVT_N; g++) begin : g_evt
      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            evt_r[g] <= 1'b0;
         end else if (evt_set[g]) begin
            evt_r[g] <= 1'b1;
         end else if (evt_clr[g]) begin
            evt_r[g] <= 1'b0;
         end
      end
   end

   // energy scan sequencer
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ed_st_r <= ED_IDLE;
         iter_left_r <= 8'h00;
         max_r <= 8'h00;
      end else begin
         unique case (ed_st_r)
            ED_IDLE: begin
               if (ed_go) begin
                  ed_st_r <= ED_RUN;
                  iter_left_r <= (iter_r == 8'h00) ? 8'h01 : iter_r;
                  max_r <= 8'h00;
               end
            end
            ED_RUN: begin
               if (ed_abort || ed_last) begin
                  ed_st_r <= ED_IDLE;
               end
               if (ed_iter_end) begin
                  max_r <= ed_max_nxt;
                  iter_left_r <= iter_left_r - 8'h01;
               end
            end
         endcase
      end
   end

   // assessment sequencer
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cca_st_r <= CCA_IDLE;
         carrier_r <= 1'b0;
         cca_age_r <= 16'h0000;
      end else begin
         unique case (cca_st_r)
            CCA_IDLE: begin
               if (cca_go) begin
                  cca_st_r <= CCA_RUN;
                  carrier_r <= 1'b0;
                  cca_age_r <= 16'h0000;
               end
            end
            CCA_RUN: begin
               carrier_r <= carrier_seen;
               cca_age_r <= cca_age_r + 16'h0001;
               if (cca_abort || cca_early || cca_end) begin
                  cca_st_r <= CCA_IDLE;
               end
            end
         endcase
      end
   end

   // result register and outputs
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         result_r <= 8'h00;
         o_energy_scan_done_event <= 1'b0;
         o_energy_scan_aborted_event <= 1'b0;
         o_medium_free_event <= 1'b0;
         o_medium_occupied_event <= 1'b0;
         o_assessment_aborted_event <= 1'b0;
         o_transmit_rampup_task <= 1'b0;
         o_receive_stop_task <= 1'b0;
         o_radio_disable_task <= 1'b0;
      end else begin
         if (ed_last) begin
            result_r <= ed_max_nxt;
         end
         if (cca_end) begin
            result_r <= (mode == MODE_TEST) ? avg_first : avg_val;
         end
         o_energy_scan_done_event <= ed_last;
         o_energy_scan_aborted_event <= ed_abort;
         o_medium_free_event <= free_ev;
         o_medium_occupied_event <= occ_ev;
         o_assessment_aborted_event <= cca_abort;
         o_transmit_rampup_task <= free_ev && shorts_r[SC_FREE_TX];
         o_receive_stop_task <= free_ev && shorts_r[SC_FREE_STOP];
         o_radio_disable_task <= occ_ev && shorts_r[SC_OCC_DIS];
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);

   sequence s_sfd_hit;
      cca_run && !tsk[TSK_CCA_ABORT] && (mode == MODE_CARRIER) && corr_on && i_sfd_detect;
   endsequence
   sequence s_outcome_idle;
      o_medium_occupied_event && (cca_st_r == CCA_IDLE);
   endsequence
   sequence s_last_pass;
      ed_run && avg_done && !tsk[TSK_ED_ABORT] && (iter_left_r == 8'h01);
   endsequence

   AST_ED_DONE: assert property (s_last_pass |=> o_energy_scan_done_event && !ed_run)
      else $error("scan did not finish after last pass");
   AST_ED_MAX: assert property (s_last_pass |=> result_r == $past(ed_max_nxt))
      else $error("scan result is not the maximum");
   AST_ED_ABORT: assert property (ed_run && tsk[TSK_ED_ABORT] |=> o_energy_scan_aborted_event && !ed_run
      && !o_energy_scan_done_event)
      else $error("scan abort not acknowledged");
   AST_CCA_WINDOW: assert property (cca_end |-> cca_age_r == WIN_CYC)
      else $error("assessment window length wrong");
   AST_THRESH: assert property (cca_end && (mode == MODE_ENERGY) |=>
      (o_medium_occupied_event == ($past(avg_val) >= $past(thr))) && (o_medium_free_event != o_medium_occupied_event))
      else $error("energy threshold decision wrong");
   AST_SFD_EARLY: assert property (s_sfd_hit |=> s_outcome_idle)
      else $error("sfd did not end assessment as occupied");
   AST_CCA_ABORT: assert property (cca_run && tsk[TSK_CCA_ABORT] |=> o_assessment_aborted_event
      && !o_medium_free_event && !o_medium_occupied_event)
      else $error("assessment abort not acknowledged");
   AST_ONE_OUTCOME: assert property ($onehot0({o_medium_free_event, o_medium_occupied_event,
      o_assessment_aborted_event}) && !(o_medium_free_event && $past(o_medium_free_event)))
      else $error("more than one assessment outcome");
   AST_SHORT_DIS: assert property (o_medium_occupied_event && $past(shorts_r[SC_OCC_DIS]) |-> o_radio_disable_task)
      else $error("disable shortcut missed");
   AST_SHORT_FREE: assert property (o_medium_free_event && $past(shorts_r[SC_FREE_TX]) &&
      $past(shorts_r[SC_FREE_STOP]) |-> o_transmit_rampup_task && o_receive_stop_task)
      else $error("free shortcuts missed");
   AST_SHORT_RDY: assert property (i_receive_rampup_done_event && shorts_r[SC_RDY_CCA] && both_idle
      && !tsk[TSK_ED_BEGIN] |=> cca_run)
      else $error("ramp-up shortcut did not start assessment");
endmodule // ecu_top

// >>> hw/ecu_pkg.sv
/*
 Constants, register map and types for the 802.15.4 energy detection and
 channel assessment unit. Assumes a single 125 MHz system clock.
*/
package ecu_pkg;
   // timing
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned SYMBOL_US = 16;
   localparam int unsigned SYMBOL_CYCLES = SYMBOL_US * CLK_MHZ;
   localparam int unsigned WINDOW_SYMBOLS = 8;
   // register byte offsets
   localparam logic [4:0] OFS_TASKS = 5'h00;
   localparam logic [4:0] OFS_EVENTS = 5'h04;
   localparam logic [4:0] OFS_SHORTS = 5'h08;
   localparam logic [4:0] OFS_ITER = 5'h0C;
   localparam logic [4:0] OFS_RESULT = 5'h10;
   localparam logic [4:0] OFS_CTRL = 5'h14;
   // task bits
   localparam int TSK_ED_BEGIN = 0;
   localparam int TSK_ED_ABORT = 1;
   localparam int TSK_CCA_BEGIN = 2;
   localparam int TSK_CCA_ABORT = 3;
   // event bits
   localparam int EVT_N = 5;
   localparam int EVT_ED_DONE = 0;
   localparam int EVT_ED_ABORTED = 1;
   localparam int EVT_FREE = 2;
   localparam int EVT_OCC = 3;
   localparam int EVT_CCA_ABORTED = 4;
   // shortcut bits
   localparam int SC_FREE_TX = 0;
   localparam int SC_FREE_STOP = 1;
   localparam int SC_OCC_DIS = 2;
   localparam int SC_RDY_CCA = 3;
   // assessment_control fields
   localparam int MODE_LSB = 0;
   localparam int THR_LSB = 8;
   localparam int CTHR_LSB = 16;
   localparam int LIM_LSB = 24;
   localparam logic [31:0] CTRL_MASK = 32'hFFFFFF07;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam logic [7:0] ITER_RST = 8'h00;
   localparam logic [3:0] SHORTS_RST = 4'h0;
   // assessment_mode_select codes
   localparam logic [2:0] MODE_ENERGY = 3'h0;
   localparam logic [2:0] MODE_CARRIER = 3'h1;
   localparam logic [2:0] MODE_AND = 3'h2;
   localparam logic [2:0] MODE_OR = 3'h3;
   localparam logic [2:0] MODE_TEST = 3'h4;
   typedef enum logic {ED_IDLE, ED_RUN} ecu_ed_st_t;
   typedef enum logic {CCA_IDLE, CCA_RUN} ecu_cca_st_t;
endpackage

// >>> hw/ecu_sym_avg.sv
/*
 Eight-symbol signal strength averager with its own symbol divider.
 Assumes the strength input is valid whenever sampled.
*/
`timescale 1ns/1ps
module ecu_sym_avg #(
   parameter int unsigned P_SYMBOL_CYCLES = ecu_pkg::SYMBOL_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic [7:0] i_rssi,
   // results
   output logic o_done,
   output logic [7:0] o_avg,
   output logic [7:0] o_first
);
   import ecu_pkg::*;
   localparam logic [15:0] DIV_LAST = 16'(P_SYMBOL_CYCLES - 1);
   logic run_r;
   logic [15:0] div_r;
   logic [2:0] sym_r;
   logic [10:0] sum_r;
   wire tick = run_r && (div_r == DIV_LAST);
   wire [10:0] sum_nxt = sum_r + {3'h0, i_rssi};
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         run_r <= 1'b0;
         div_r <= 16'h0000;
         sym_r <= 3'h0;
         sum_r <= 11'h000;
         o_done <= 1'b0;
         o_avg <= 8'h00;
         o_first <= 8'h00;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            run_r <= 1'b1;
            div_r <= 16'h0000;
            sym_r <= 3'h0;
            sum_r <= 11'h000;
         end else if (i_stop) begin
            run_r <= 1'b0;
         end else if (run_r) begin
            div_r <= tick ? 16'h0000 : div_r + 16'h0001;
            // one sample per symbol, eight averaged
            if (tick) begin
               sum_r <= sum_nxt;
               sym_r <= sym_r + 3'h1;
               if (sym_r == 3'h0) begin
                  o_first <= i_rssi;
               end
               if (sym_r == 3'h7) begin
                  run_r <= 1'b0;
                  o_done <= 1'b1;
                  o_avg <= sum_nxt[10:3];
               end
            end
         end
      end
   end
endmodule // ecu_sym_avg

// >>> hw/ecu_peak_cnt.sv
/*
 Correlator peak counter for the carrier sense assessment.
 Assumes one peak strobe per correlator peak with its value alongside.
*/
`timescale 1ns/1ps
module ecu_peak_cnt (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_clear,
   input wire logic i_enable,
   // correlator
   input wire logic i_peak,
   input wire logic [7:0] i_value,
   input wire logic [7:0] i_threshold,
   input wire logic [7:0] i_limit,
   // result
   output logic o_hit
);
   logic [7:0] cnt_r;
   wire take = i_enable && i_peak && (i_value > i_threshold) && (cnt_r != 8'hFF);
   wire [7:0] cnt_nxt = take ? cnt_r + 8'h01 : cnt_r;
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_r <= 8'h00;
         o_hit <= 1'b0;
      end else if (i_clear) begin
         cnt_r <= 8'h00;
         o_hit <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         o_hit <= (i_limit != 8'h00) && (cnt_nxt >= i_limit);
      end
   end
endmodule // ecu_peak_cnt

// >>> tb/ecu_top_tb_top.sv
/*
 Self-checking bench for the energy scan and channel assessment unit.
 Assumes ecu_pkg and ecu_top are compiled first; symbol period shortened to 4 cycles.
*/
`timescale 1ns/1ps
module ecu_top_tb_top;
   import ecu_pkg::*;
   localparam int unsigned SYM = 4;
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h00000000;
   logic [7:0] rssi = 8'h00;
   logic sfd = 1'b0;
   logic frx = 1'b0;
   logic pk = 1'b0;
   logic rdy = 1'b0;
   logic [7:0] cv = 8'hC0;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   wire [4:0] ev;
   wire [2:0] tk;
   logic [7:0] ev_q[$];
   logic [31:0] rd_q[$];
   logic [7:0] smp[24];
   logic [7:0] res_exp = 8'h00;
   int err_count = 0;
   int checks = 0;
   int seed = 30342;

   always #4 i_sys_clk = ~i_sys_clk;

   ecu_top #(.P_SYMBOL_CYCLES(SYM)) u_dut (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_address(adr), .i_read(rd), .i_write(wr),
      .i_writedata(wdat), .i_byteenable(4'hF), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_rssi(rssi), .i_sfd_detect(sfd), .i_frame_rx_active(frx), .i_corr_peak(pk), .i_corr_value(cv),
      .i_receive_rampup_done_event(rdy), .o_energy_scan_done_event(ev[EVT_ED_DONE]),
      .o_energy_scan_aborted_event(ev[EVT_ED_ABORTED]), .o_medium_free_event(ev[EVT_FREE]),
      .o_medium_occupied_event(ev[EVT_OCC]), .o_assessment_aborted_event(ev[EVT_CCA_ABORTED]),
      .o_transmit_rampup_task(tk[2]), .o_receive_stop_task(tk[1]), .o_radio_disable_task(tk[0]));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // outputs are read before the edge's updates land, so pulses are seen in their own cycle
   always @(posedge i_sys_clk) begin
      if (!i_sys_rst && (ev !== 5'h00 || tk !== 3'h0)) begin
         if (ev_q.size() == 0) check({24'h0, ev, tk}, 32'h0, "stray event");
         else check({24'h0, ev, tk}, {24'h0, ev_q.pop_front()}, "event");
      end
      if (!i_sys_rst && o_waitrequest === 1'b0 && rd) check(o_readdata, rd_q.pop_front(), "read");
   end

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) check(32'h1, 32'h0, "bus timeout");
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h00000000);
   endtask

   task automatic drain(input string name);
      int n;
      n = 0;
      while (ev_q.size() != 0 && n < 1000) begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n >= 1000) check(32'h1, 32'h0, "outcome timeout");
      repeat (4) @(posedge i_sys_clk);
      $display("test %s done", name);
   endtask

   // values change mid-symbol so a one-cycle doubt about the start edge cannot move a sample
   task automatic win(input int nw, input int sfd_at, input int npk);
      for (int j = 0; j < 8 * nw; j++) begin
         repeat (2) @(posedge i_sys_clk);
         rssi <= smp[j];
         sfd <= (j + 1 == sfd_at);
         pk <= (j >= 1 && j <= npk);
         @(posedge i_sys_clk);
         sfd <= 1'b0;
         pk <= 1'b0;
         @(posedge i_sys_clk);
      end
   endtask

   function automatic logic [7:0] avg(input int w);
      logic [10:0] s;
      s = 11'h000;
      for (int j = 0; j < 8; j++) s += {3'h0, smp[8 * w + j]};
      return s[10:3];
   endfunction

   task automatic gen();
      for (int j = 0; j < 24; j++) smp[j] = 8'($random(seed));
   endtask

   task automatic scan(input logic [7:0] cnt);
      int nw;
      logic [7:0] m;
      nw = (cnt == 8'h00) ? 1 : int'(cnt);
      gen();
      m = 8'h00;
      for (int w = 0; w < nw; w++) if (avg(w) > m) m = avg(w);
      bus(1'b1, OFS_ITER, {24'h0, cnt});
      ev_q.push_back({5'(1 << EVT_ED_DONE), 3'b000});
      bus(1'b1, OFS_TASKS, 32'(1 << TSK_ED_BEGIN));
      // no sfd or peaks while measuring energy
      win(nw, 0, 0);
      drain("energy scan");
      res_exp = m;
      rdchk(OFS_RESULT, {24'h0, m});
   endtask

   task automatic cca(input logic [2:0] mode, input int dthr, input logic [7:0] lim, input int sfd_at,
                      input int npk, input logic fa);
      logic [7:0] a;
      logic [7:0] thr;
      logic eb, cb, busy, early;
      gen();
      a = avg(0);
      thr = a + 8'(dthr);
      eb = (a >= thr);
      cb = (sfd_at != 0) || fa || (lim != 8'h00 && npk >= lim && cv > 8'h80);
      case (mode)
         MODE_CARRIER: busy = cb;
         MODE_AND: busy = eb && cb;
         MODE_OR: busy = eb || cb;
         default: busy = eb;
      endcase
      early = (mode == MODE_CARRIER) && (lim != 8'h00) && cb;
      frx <= fa;
      bus(1'b1, OFS_CTRL, {lim, 8'h80, thr, 5'h00, mode});
      // shortcut tasks ride with the outcome
      ev_q.push_back(busy ? {5'(1 << EVT_OCC), 3'b001} : {5'(1 << EVT_FREE), 3'b110});
      bus(1'b1, OFS_TASKS, 32'(1 << TSK_CCA_BEGIN));
      win(1, sfd_at, npk);
      frx <= 1'b0;
      drain("assessment");
      if (!early) begin
         // first sample only in test mode
         res_exp = (mode == MODE_TEST) ? smp[0] : a;
         rdchk(OFS_RESULT, {24'h0, res_exp});
      end
   endtask

   task automatic abort(input int tb, input int ta, input logic [7:0] note);
      ev_q.push_back(note);
      bus(1'b1, OFS_TASKS, 32'(1 << tb));
      repeat (10) @(posedge i_sys_clk);
      bus(1'b1, OFS_TASKS, 32'(1 << ta));
      drain("abort");
      rdchk(OFS_RESULT, {24'h0, res_exp});
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #200000;
      check(32'h1, 32'h0, "watchdog expired");
      finish_test();
   end

   initial begin
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      rdchk(OFS_CTRL, 32'h0);
      rdchk(OFS_ITER, 32'h0);
      rdchk(OFS_SHORTS, 32'h0);
      rdchk(OFS_RESULT, 32'h0);
      bus(1'b1, 5'h18, 32'hFFFFFFFF);
      rdchk(5'h18, 32'h0);
      bus(1'b1, OFS_CTRL, 32'hFFFFFFFF);
      rdchk(OFS_CTRL, CTRL_MASK);
      bus(1'b1, OFS_SHORTS, 32'h0000000F);
      rdchk(OFS_SHORTS, 32'h0000000F);
      $display("test registers done");
      scan(8'h00);
      scan(8'h03);
      abort(TSK_ED_BEGIN, TSK_ED_ABORT, {5'(1 << EVT_ED_ABORTED), 3'b000});
      for (int d = 0; d < 2; d++) cca(MODE_ENERGY, d, 8'h00, 0, 0, 1'b0);
      cca(MODE_TEST, 1, 8'h00, 0, 0, 1'b0);
      cca(MODE_CARRIER, 0, 8'h00, 5, 0, 1'b0);
      cca(MODE_CARRIER, 0, 8'h00, 0, 0, 1'b1);
      cca(MODE_CARRIER, 0, 8'h00, 0, 0, 1'b0);
      cca(MODE_CARRIER, 0, 8'h02, 3, 0, 1'b0);
      cca(MODE_CARRIER, 0, 8'h02, 0, 2, 1'b0);
      cca(MODE_CARRIER, 0, 8'h02, 0, 1, 1'b0);
      // peaks at the threshold are not counted
      cv <= 8'h80;
      @(posedge i_sys_clk);
      cca(MODE_CARRIER, 0, 8'h02, 0, 2, 1'b0);
      cv <= 8'hC0;
      for (int k = 0; k < 4; k++) cca(k[0] ? MODE_OR : MODE_AND, k >> 1, 8'h00, (k >> 1) * 4, 0, 1'b0);
      abort(TSK_CCA_BEGIN, TSK_CCA_ABORT, {5'(1 << EVT_CCA_ABORTED), 3'b000});
      bus(1'b1, OFS_TASKS, 32'(1 << TSK_ED_ABORT | 1 << TSK_CCA_ABORT));
      drain("idle abort");
      gen();
      bus(1'b1, OFS_CTRL, 32'h00000000);
      ev_q.push_back({5'(1 << EVT_OCC), 3'b001});
      @(posedge i_sys_clk);
      rdy <= 1'b1;
      @(posedge i_sys_clk);
      rdy <= 1'b0;
      win(1, 0, 0);
      drain("rampup shortcut");
      // sticky event record, then write-one-to-clear
      rdchk(OFS_EVENTS, 32'h0000001F);
      bus(1'b1, OFS_EVENTS, 32'h0000001F);
      rdchk(OFS_EVENTS, 32'h00000000);
      $display("test event register done");
      finish_test();
   end
endmodule // ecu_top_tb_top
